// file: common/mtau_consts.vh
// constants for the motion table alarm unit: register map, codes, fields
// assumes a 32-bit ahb-lite slave with word registers
`ifndef MTAU_CONSTS_VH
`define MTAU_CONSTS_VH

// register byte offsets
`define MTAU_ADDR_CTRL 8'h00
`define MTAU_ADDR_STATUS 8'h04
`define MTAU_ADDR_CODE 8'h08
`define MTAU_ADDR_WARN 8'h0C
`define MTAU_ADDR_REGDIST 8'h10
`define MTAU_ADDR_DECELDIST 8'h14

// ctrl register fields (write)
`define MTAU_CTRL_ALM_RESET 0
`define MTAU_CTRL_WARN_CLEAR 1

// status register fields (read)
`define MTAU_ST_ALARM 0
`define MTAU_ST_GROUP_EF9 1
`define MTAU_ST_GROUP_9F9 2
`define MTAU_ST_STOP 3
`define MTAU_ST_PROG_LOCK 4
`define MTAU_ST_ZONE_SUSPECT 5
`define MTAU_ST_JOG_LOCK 6
`define MTAU_ST_CHECK_DONE 7

// error codes (16-bit displayed codes)
`define MTAU_CODE_NONE 16'h0000
`define MTAU_CODE_PROG_SUM 16'hE19A
`define MTAU_CODE_PROG_VER 16'hE1AA
`define MTAU_CODE_PROG_RANGE 16'hE1BA
`define MTAU_CODE_ZONE_SUM 16'hE1CA
`define MTAU_CODE_ZONE_VER 16'hE1DA
`define MTAU_CODE_ZONE_RANGE 16'hE1EA
`define MTAU_CODE_JOG_SUM 16'hE1FA
`define MTAU_CODE_JOG_VER 16'hE21A
`define MTAU_CODE_JOG_RANGE 16'hE22A
`define MTAU_CODE_REG_DIST 16'hE23A
`define MTAU_CODE_HOME_FAIL 16'hE24A
`define MTAU_CODE_HOME_SPEED 16'hE25A
`define MTAU_CODE_PROG_CANCEL 16'hE44E
`define MTAU_CODE_JOG_CANCEL 16'hE46E

// reset values
`define MTAU_RST_WORD 32'h0000_0000

`endif

// file: core/mtau_ahb_slave.v
// ahb-lite slave front end: captures the address phase, answers in zero wait
// assumes single word transfers from one master; response is always okay
`timescale 1ns/100ps
`default_nettype none

module mtau_ahb_slave
(
    input wire i_clk,
    input wire i_rst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    output reg o_wr_en,
    output reg o_rd_en,
    output reg [7:0] o_addr
);

    // data phase strobes follow a taken nonseq or seq address phase
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_wr_en <= 1'b0;
            o_rd_en <= 1'b0;
            o_addr <= 8'h00;
        end
        else if (i_hready)
        begin
            o_wr_en <= i_hsel & i_htrans[1] & i_hwrite;
            o_rd_en <= i_hsel & i_htrans[1] & ~i_hwrite;
            o_addr <= i_haddr[7:0];
        end
    end

endmodule

`default_nettype wire

// file: core/mtau_top.v
// motion table alarm unit: power-up table checks, motion faults, error code
// assumes table check results and motion status arrive as synchronous levels
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mtau_consts.vh"

// Contract
// - program checksum bad: E19A, EF9, stop
// - program version mismatch: E1AA under EF9
// - program entry out of range: E1BA
// - zone checksum bad: E1CA under EF9
// - zone version mismatch: E1DA under EF9
// - zone entry out of range: E1EA
// - jog checksum bad: E1FA under EF9
// - jog version mismatch: E21A under EF9
// - jog entry out of range: E22A
// - registration distance short: E23A, stop
// - pressing homing torque released: E24A, 9F9
// - homing deviation excessive: E25A, 9F9, stop
// - program start after reset gives E44E
// - zone reset allowed, outputs flagged suspect
// - jog start after reset gives E46E
module mtau_top
(
    input wire i_clk,
    input wire i_rst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire i_check_valid,
    input wire [2:0] i_prog_fault,
    input wire [2:0] i_zone_fault,
    input wire [2:0] i_jog_fault,
    input wire i_registration_start_input,
    input wire i_pressing_homing,
    input wire i_torque_at_limit,
    input wire i_torque_limit_on,
    input wire i_homing_done,
    input wire i_homing_active,
    input wire i_deviation_excess,
    input wire i_prog_start,
    input wire i_jog_start,
    output reg o_alarm,
    output reg o_first_group_stop,
    output reg [15:0] o_error_code,
    output reg o_prog_refused,
    output reg o_jog_refused,
    output reg o_zone_suspect
);

    // fault vector bit positions, also the priority when faults coincide
    localparam F_PSUM = 0;
    localparam F_PVER = 1;
    localparam F_PRNG = 2;
    localparam F_ZSUM = 3;
    localparam F_ZVER = 4;
    localparam F_ZRNG = 5;
    localparam F_JSUM = 6;
    localparam F_JVER = 7;
    localparam F_JRNG = 8;
    localparam F_REGISTRATION_DISTANCE = 9;
    localparam F_HFAIL = 10;
    localparam F_HSPD = 11;

    // check sequence states
    localparam S_WAIT = 2'b00;
    localparam S_RUN = 2'b01;

    wire wr_en;
    wire rd_en;
    wire [7:0] addr;
    reg [1:0] state;
    reg [31:0] registration_distance;
    reg [31:0] decel_distance;
    reg [15:0] warn_code;
    reg prog_lock;
    reg jog_lock;
    reg group_9f9;
    reg torque_seen;
    reg reg_start_d;
    reg [11:0] fault;
    reg [15:0] next_code;
    reg next_9f9;
    reg [15:0] next_warn;
    reg [31:0] next_rdata;
    wire alm_reset;
    wire warn_clear;
    wire reg_start_edge;
    wire home_release;

    mtau_ahb_slave u_slave
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hready(i_hready),
        .o_wr_en(wr_en),
        .o_rd_en(rd_en),
        .o_addr(addr)
    );

    // software requests arrive as data-phase writes to the control word
    assign alm_reset = wr_en & (addr == `MTAU_ADDR_CTRL) & i_hwdata[`MTAU_CTRL_ALM_RESET];
    assign warn_clear = wr_en & (addr == `MTAU_ADDR_CTRL) & i_hwdata[`MTAU_CTRL_WARN_CLEAR];
    assign reg_start_edge = i_registration_start_input & ~reg_start_d;
    // releasing the limit during pressing homing before homing ends, whether or not torque reached it
    assign home_release = i_pressing_homing & ~i_torque_limit_on & ~i_homing_done
        & (torque_seen | 1'b1);

    // collect this cycle's detected faults
    always @*
    begin
        fault = 12'h000;
        if (state == S_WAIT && i_check_valid)
        begin
            fault[F_PSUM] = i_prog_fault[0];
            fault[F_PVER] = i_prog_fault[1];
            fault[F_PRNG] = i_prog_fault[2];
            fault[F_ZSUM] = i_zone_fault[0];
            fault[F_ZVER] = i_zone_fault[1];
            fault[F_ZRNG] = i_zone_fault[2];
            fault[F_JSUM] = i_jog_fault[0];
            fault[F_JVER] = i_jog_fault[1];
            fault[F_JRNG] = i_jog_fault[2];
        end
        fault[F_REGISTRATION_DISTANCE] = reg_start_edge & (registration_distance < decel_distance);
        fault[F_HFAIL] = home_release & i_homing_active;
        fault[F_HSPD] = i_homing_active & i_deviation_excess;
    end

    // lowest set bit wins; a held alarm blocks any newer code
    always @*
    begin
        next_code = o_error_code;
        next_9f9 = group_9f9;
        if (!o_alarm || alm_reset)
        begin
            if (alm_reset)
            begin
                next_code = `MTAU_CODE_NONE;
                next_9f9 = 1'b0;
            end
            next_9f9 = fault[F_HFAIL] | fault[F_HSPD];
            if (fault[F_PSUM]) next_code = `MTAU_CODE_PROG_SUM;
            else if (fault[F_PVER]) next_code = `MTAU_CODE_PROG_VER;
            else if (fault[F_PRNG]) next_code = `MTAU_CODE_PROG_RANGE;
            else if (fault[F_ZSUM]) next_code = `MTAU_CODE_ZONE_SUM;
            else if (fault[F_ZVER]) next_code = `MTAU_CODE_ZONE_VER;
            else if (fault[F_ZRNG]) next_code = `MTAU_CODE_ZONE_RANGE;
            else if (fault[F_JSUM]) next_code = `MTAU_CODE_JOG_SUM;
            else if (fault[F_JVER]) next_code = `MTAU_CODE_JOG_VER;
            else if (fault[F_JRNG]) next_code = `MTAU_CODE_JOG_RANGE;
            else if (fault[F_REGISTRATION_DISTANCE]) next_code = `MTAU_CODE_REG_DIST;
            else if (fault[F_HFAIL]) next_code = `MTAU_CODE_HOME_FAIL;
            else if (fault[F_HSPD]) next_code = `MTAU_CODE_HOME_SPEED;
            if (fault[8:0] != 9'h000 || fault[F_REGISTRATION_DISTANCE])
            begin
                next_9f9 = 1'b0;
            end
        end
    end

    // refused starts raise a warning code; a new refusal beats a clear
    always @*
    begin
        next_warn = warn_code;
        if (warn_clear)
        begin
            next_warn = `MTAU_CODE_NONE;
        end
        if (i_prog_start && prog_lock)
        begin
            next_warn = `MTAU_CODE_PROG_CANCEL;
        end
        else if (i_jog_start && jog_lock)
        begin
            next_warn = `MTAU_CODE_JOG_CANCEL;
        end
    end

    // alarm state, table locks and motion outputs
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= S_WAIT;
            o_alarm <= 1'b0;
            o_first_group_stop <= 1'b0;
            o_error_code <= `MTAU_CODE_NONE;
            group_9f9 <= 1'b0;
            prog_lock <= 1'b0;
            jog_lock <= 1'b0;
            o_zone_suspect <= 1'b0;
            warn_code <= `MTAU_CODE_NONE;
            o_prog_refused <= 1'b0;
            o_jog_refused <= 1'b0;
            torque_seen <= 1'b0;
            reg_start_d <= 1'b0;
        end
        else
        begin
            reg_start_d <= i_registration_start_input;
            if (i_check_valid)
            begin
                state <= S_RUN; // checks run once per power-up
            end
            torque_seen <= i_pressing_homing & (torque_seen | i_torque_at_limit);
            o_error_code <= next_code;
            group_9f9 <= next_9f9;
            o_alarm <= (next_code != `MTAU_CODE_NONE);
            // every listed fault stops by the first-group method
            o_first_group_stop <= (next_code != `MTAU_CODE_NONE);
            if (alm_reset && o_alarm)
            begin
                // a reset locks a faulted program or jog table against later starts and flags a faulted zone table suspect
                if (o_error_code == `MTAU_CODE_PROG_SUM || o_error_code == `MTAU_CODE_PROG_VER
                    || o_error_code == `MTAU_CODE_PROG_RANGE)
                begin
                    prog_lock <= 1'b1;
                end
                if (o_error_code == `MTAU_CODE_ZONE_SUM || o_error_code == `MTAU_CODE_ZONE_VER
                    || o_error_code == `MTAU_CODE_ZONE_RANGE)
                begin
                    o_zone_suspect <= 1'b1;
                end
                if (o_error_code == `MTAU_CODE_JOG_SUM || o_error_code == `MTAU_CODE_JOG_VER
                    || o_error_code == `MTAU_CODE_JOG_RANGE)
                begin
                    jog_lock <= 1'b1;
                end
            end
            warn_code <= next_warn;
            o_prog_refused <= i_prog_start & prog_lock;
            o_jog_refused <= i_jog_start & jog_lock;
        end
    end

    // writable distance registers for the registration check
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            registration_distance <= `MTAU_RST_WORD;
            decel_distance <= `MTAU_RST_WORD;
        end
        else if (wr_en)
        begin
            if (addr == `MTAU_ADDR_REGDIST)
            begin
                registration_distance <= i_hwdata;
            end
            if (addr == `MTAU_ADDR_DECELDIST)
            begin
                decel_distance <= i_hwdata;
            end
        end
    end

    // read mux, selected from the live address-phase i_haddr
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (i_haddr[7:0])
            `MTAU_ADDR_STATUS:
            begin
                next_rdata[`MTAU_ST_ALARM] = o_alarm;
                next_rdata[`MTAU_ST_GROUP_EF9] = o_alarm & ~group_9f9;
                next_rdata[`MTAU_ST_GROUP_9F9] = o_alarm & group_9f9;
                next_rdata[`MTAU_ST_STOP] = o_first_group_stop;
                next_rdata[`MTAU_ST_PROG_LOCK] = prog_lock;
                next_rdata[`MTAU_ST_ZONE_SUSPECT] = o_zone_suspect;
                next_rdata[`MTAU_ST_JOG_LOCK] = jog_lock;
                next_rdata[`MTAU_ST_CHECK_DONE] = (state == S_RUN);
            end
            `MTAU_ADDR_CODE: next_rdata = {16'h0000, o_error_code};
            `MTAU_ADDR_WARN: next_rdata = {16'h0000, warn_code};
            `MTAU_ADDR_REGDIST: next_rdata = registration_distance;
            `MTAU_ADDR_DECELDIST: next_rdata = decel_distance;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // zero-wait answer: read data registered at the address-phase edge
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
            begin
                o_hrdata <= next_rdata;
            end
        end
    end

endmodule

`default_nettype wire

// file: verification/mtau_axis_model.sv
// axis and host stand-in: table check results and motion levels per command
// assumes the bench changes i_cmd just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module mtau_axis_model
(
    input wire logic [3:0] i_cmd,
    output logic o_check_valid,
    output logic [2:0] o_prog_fault,
    output logic [2:0] o_zone_fault,
    output logic [2:0] o_jog_fault,
    output logic o_reg_start,
    output logic o_pressing,
    output logic o_at_limit,
    output logic o_limit_on,
    output logic o_homing_active,
    output logic o_dev_excess,
    output logic o_prog_start,
    output logic o_jog_start
);
// 1..9 corrupt one table, 10 registration, 11 limit dropped, 12 deviation
always @*
begin
    o_check_valid = i_cmd != 4'h0;
    o_prog_fault = (i_cmd >= 4'h1 && i_cmd <= 4'h3) ? 3'h1 << (i_cmd - 4'h1) : 3'h0;
    o_zone_fault = (i_cmd >= 4'h4 && i_cmd <= 4'h6) ? 3'h1 << (i_cmd - 4'h4) : 3'h0;
    o_jog_fault = (i_cmd >= 4'h7 && i_cmd <= 4'h9) ? 3'h1 << (i_cmd - 4'h7) : 3'h0;
    o_reg_start = i_cmd == 4'hA;
    o_pressing = i_cmd == 4'hB;
    o_at_limit = i_cmd == 4'hB;
    // limit stays applied except when the pressing fault is wanted
    o_limit_on = i_cmd != 4'hB;
    o_homing_active = i_cmd == 4'hB || i_cmd == 4'hC;
    o_dev_excess = i_cmd == 4'hC;
    o_prog_start = i_cmd == 4'hD;
    o_jog_start = i_cmd == 4'hE;
end
endmodule
`default_nettype wire

// file: verification/mtau_top_asserts.sv
// checker for the alarm unit: fault codes, hold until reset, start lockouts
// assumes it is bound to mtau_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module mtau_top_asserts
(
    input wire i_clk,
    input wire i_rst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    input wire i_check_valid,
    input wire [2:0] i_prog_fault,
    input wire i_registration_start_input,
    input wire i_pressing_homing,
    input wire i_torque_limit_on,
    input wire i_homing_done,
    input wire i_homing_active,
    input wire i_deviation_excess,
    input wire i_prog_start,
    input wire i_jog_start,
    input wire o_alarm,
    input wire o_first_group_stop,
    input wire [15:0] o_error_code,
    input wire o_prog_refused,
    input wire o_jog_refused,
    input wire o_zone_suspect
);
logic seen, reg_q, wr_q, pl, jl;
wire first = i_check_valid && !seen;
wire clr = wr_q && i_hwdata[0];
wire hi = first || (i_registration_start_input && !reg_q);
wire hf = i_pressing_homing && !i_torque_limit_on && !i_homing_done && i_homing_active;
// mirror of what the unit must remember; the bus decode looks at the low byte only
always @(posedge i_clk)
begin
    seen <= !i_rst && (seen || i_check_valid);
    reg_q <= !i_rst && i_registration_start_input;
    wr_q <= !i_rst && i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr[7:0] == 8'h00;
    pl <= !i_rst && (pl || clr && o_alarm && o_error_code inside {16'hE19A, 16'hE1AA, 16'hE1BA});
    jl <= !i_rst && (jl || clr && o_alarm && o_error_code inside {16'hE1FA, 16'hE21A, 16'hE22A});
end
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
sequence s_code(logic [15:0] c);
    o_alarm && o_error_code == c;
endsequence
AST_STOP: assert property (o_first_group_stop == o_alarm)
    else $error("stop request differs from alarm");
AST_PROG_SUM: assert property (first && !o_alarm && i_prog_fault[0] |=> s_code(16'hE19A))
    else $error("program checksum code missing");
AST_PROG_VER: assert property (first && !o_alarm && i_prog_fault == 3'h2 |=> s_code(16'hE1AA))
    else $error("program version code missing");
AST_PROG_RANGE: assert property (first && !o_alarm && i_prog_fault == 3'h4 |=> s_code(16'hE1BA))
    else $error("program range code missing");
AST_HOLD: assert property (o_alarm && !clr |=> o_alarm && $stable(o_error_code))
    else $error("alarm code not held");
AST_HOME_FAIL: assert property (!o_alarm && !hi && hf |=> s_code(16'hE24A))
    else $error("homing failure code missing");
AST_DEVIATION: assert property (!o_alarm && !hi && !hf && i_homing_active
    && i_deviation_excess |=> s_code(16'hE25A))
    else $error("homing deviation code missing");
AST_PROG_REFUSE: assert property (pl && i_prog_start |=> o_prog_refused)
    else $error("locked program start not refused");
AST_JOG_REFUSE: assert property (jl && i_jog_start |=> o_jog_refused)
    else $error("locked jog start not refused");
AST_ZONE: assert property (clr && o_alarm && o_error_code inside {16'hE1CA, 16'hE1DA, 16'hE1EA}
    |=> o_zone_suspect)
    else $error("zone suspect flag missing");
endmodule
bind mtau_top mtau_top_asserts chk_u (.*);
`default_nettype wire

// file: verification/motion_table_alarm_unit_tb.sv
// bench for the alarm unit: table faults, motion faults, lockouts, bus map
// waits on hready rather than assuming a zero-wait slave; partner drives the motion levels except i_homing_done, which the bench sets
`timescale 1ns/100ps
`default_nettype none
module motion_table_alarm_unit_tb;
logic i_clk = 1'h0, i_rst = 1'h1, i_hsel = 1'h0, i_hwrite = 1'h0;
logic [1:0] i_htrans = 2'h0;
logic [31:0] i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000, rd;
logic [3:0] cmd = 4'h0;
wire [2:0] i_hsize = 3'h2;
logic i_homing_done = 1'h0;
wire [31:0] o_hrdata;
wire [15:0] o_error_code;
wire [2:0] i_prog_fault, i_zone_fault, i_jog_fault;
wire o_hreadyout, o_hresp, o_alarm, o_first_group_stop, o_prog_refused, o_jog_refused;
wire o_zone_suspect, i_check_valid, i_registration_start_input, i_pressing_homing;
wire i_torque_at_limit, i_torque_limit_on, i_homing_active, i_deviation_excess;
wire i_prog_start, i_jog_start;
wire i_hready = o_hreadyout;
int n_fail = 0, n_compared = 0;
// expected code per corrupted table check, command 1 in the top slice
localparam logic [143:0] CODES = {16'hE19A, 16'hE1AA, 16'hE1BA, 16'hE1CA, 16'hE1DA,
    16'hE1EA, 16'hE1FA, 16'hE21A, 16'hE22A};
always #50 i_clk = ~i_clk;
mtau_top dut_u (.*);
mtau_axis_model partner_u (.i_cmd(cmd), .o_check_valid(i_check_valid),
    .o_prog_fault(i_prog_fault), .o_zone_fault(i_zone_fault), .o_jog_fault(i_jog_fault),
    .o_reg_start(i_registration_start_input), .o_pressing(i_pressing_homing),
    .o_at_limit(i_torque_at_limit), .o_limit_on(i_torque_limit_on),
    .o_homing_active(i_homing_active), .o_dev_excess(i_deviation_excess),
    .o_prog_start(i_prog_start), .o_jog_start(i_jog_start));
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
        n_fail++;
        $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
endtask
// single word transfer; hready is judged at rising edges, never assumed zero wait
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'h1;
    i_hwrite <= w;
    i_haddr <= {24'h00_0000, a};
    i_htrans <= 2'h2;
    do @(posedge i_clk); while (o_hreadyout !== 1'h1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'h1);
    rd = o_hrdata;
    chk({31'h0, o_hresp}, 32'h0000_0000);
    i_hsel <= 1'h0;
endtask
task put(input logic [3:0] c);
    @(posedge i_clk);
    cmd <= c;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
endtask
task see(input logic [15:0] c, input logic a);
    // look away from the launching edge so registered outputs have settled
    @(negedge i_clk);
    chk({14'h0, o_alarm, o_first_group_stop, o_error_code}, {14'h0, a, a, c});
endtask
// reset held twelve cycles, then the table check result is offered
task restart(input logic [3:0] c);
    @(posedge i_clk);
    i_rst <= 1'h1;
    cmd <= 4'h0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'h0;
    put(c);
endtask
task t_tables;
    logic pr, jr;
    for (int i = 1; i <= 9; i++)
    begin
        restart(i[3:0]);
        see(CODES[16 * (9 - i) +: 16], 1'h1);
        bus(1'h0, 8'h04, 32'h0000_0000);
        chk(rd & 32'h0000_008F, 32'h0000_008B);
        bus(1'h1, 8'h00, 32'h0000_0001);
        // zone faults start a program: it must not be refused
        @(posedge i_clk);
        cmd <= i >= 7 ? 4'hE : 4'hD;
        pr = 1'h0;
        jr = 1'h0;
        repeat (5)
        begin
            @(negedge i_clk);
            pr |= o_prog_refused;
            jr |= o_jog_refused;
        end
        chk({29'h0, pr, jr, o_zone_suspect}, {29'h0, i <= 3, i >= 7, i >= 4 && i <= 6});
        bus(1'h0, 8'h0C, 32'h0000_0000);
        chk(rd, i <= 3 ? 32'h0000_E44E : i >= 7 ? 32'h0000_E46E : 32'h0000_0000);
    end
    $display("table fault test done");
endtask
task t_motion;
    restart(4'hF);
    see(16'h0000, 1'h0);
    bus(1'h1, 8'h10, 32'h0000_0009);
    bus(1'h1, 8'h14, 32'h0000_0009);
    bus(1'h0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0009);
    put(4'hA);
    see(16'h0000, 1'h0);
    put(4'h0);
    bus(1'h1, 8'h10, 32'h0000_0005);
    put(4'hA);
    see(16'hE23A, 1'h1);
    put(4'hC);
    see(16'hE23A, 1'h1);
    put(4'h0);
    bus(1'h1, 8'h00, 32'h0000_0001);
    see(16'h0000, 1'h0);
    // limit dropped once homing has completed is no failure
    @(posedge i_clk);
    i_homing_done <= 1'h1;
    put(4'hB);
    see(16'h0000, 1'h0);
    put(4'h0);
    @(posedge i_clk);
    i_homing_done <= 1'h0;
    put(4'hB);
    see(16'hE24A, 1'h1);
    bus(1'h0, 8'h04, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'h0000_000D);
    put(4'h0);
    bus(1'h1, 8'h00, 32'h0000_0001);
    put(4'hC);
    see(16'hE25A, 1'h1);
    // unmapped place: write ignored, read gives zero
    bus(1'h1, 8'h20, 32'hFFFF_FFFF);
    bus(1'h0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("motion fault test done");
endtask
task report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
// main sequence
initial
begin
    t_tables;
    t_motion;
    report_and_stop;
end
// watchdog: the whole run needs well under 1000 cycles
initial
begin
    #200_000;
    n_fail++;
    report_and_stop;
end
endmodule
`default_nettype wire
